// ===== rtl/gecio_top.sv
`timescale 1ns/1ps
module gecio_top
  import gecio_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYC_DEF,
  parameter int unsigned SETTLE_CYC   = SETTLE_CYC_DEF
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_select_line_a_n,
  input  wire logic                 i_select_line_b_n,
  input  wire logic                 i_peak_select_n,
  input  wire logic                 i_spindle_ascend_n,
  input  wire logic                 i_spindle_descend_in_n,
  input  wire logic                 i_pedal_in_n,
  input  wire logic                 i_hold_n,
  input  wire logic                 i_preset_n,
  input  wire logic                 i_foot_switch_n,
  input  wire logic [2:0]           i_judge_sel,
  input  wire logic                 i_error_event,
  input  wire logic                 i_count_mode,
  input  wire logic                 i_top_dead,
  input  wire logic                 i_work_detect,
  input  wire logic [DISP_W-1:0]    i_live_value,
  output logic      [NUM_JUDGE-1:0] o_judge_out_o,
  output logic      [NUM_JUDGE-1:0] o_judge_out_oe,
  output logic                      o_count_mode_out_o,
  output logic                      o_count_mode_out_oe,
  output logic                      o_top_dead_point_out_o,
  output logic                      o_top_dead_point_out_oe,
  output logic                      o_workpiece_out_o,
  output logic                      o_workpiece_out_oe,
  output logic                      o_motor_up,
  output logic                      o_motor_down,
  output gecio_speed_t              o_motor_speed,
  output gecio_peak_t               o_peak_mode,
  output logic                      o_hold_active,
  output logic      [DISP_W-1:0]    o_display_value,
  output logic                      o_error_pending,
  output logic                      o_error_clear,
  output logic                      o_preset_load,
  output logic                      o_peak_clear,
  output logic                      o_pedal_press
);

  //----------------------------------------------------------------------------
  // Decoding helpers
  //----------------------------------------------------------------------------
  // Peak clear replaces preset only while hold is in force and a peak mode is chosen.
  function automatic logic peak_hold_active(input logic hold, input gecio_peak_t mode);
    return hold && (mode != GECIO_PK_CURRENT);
  endfunction

  // A motion request counts only while the opposite request is absent.
  function automatic logic sole_request(input logic mine, input logic other);
    return mine && !other;
  endfunction

  //----------------------------------------------------------------------------
  // Input conditioning
  //----------------------------------------------------------------------------
  logic [NUM_IN-1:0] pin_n;
  gecio_in_if        in_bus ();

  assign pin_n[IN_SEL_A]  = i_select_line_a_n;
  assign pin_n[IN_SEL_B]  = i_select_line_b_n;
  assign pin_n[IN_PEAK]   = i_peak_select_n;
  assign pin_n[IN_UP]     = i_spindle_ascend_n;
  assign pin_n[IN_DOWN]   = i_spindle_descend_in_n;
  assign pin_n[IN_PEDAL]  = i_pedal_in_n;
  assign pin_n[IN_HOLD]   = i_hold_n;
  assign pin_n[IN_PRESET] = i_preset_n;
  assign pin_n[IN_FOOT]   = i_foot_switch_n;

  gecio_debounce #(
    .DEB_CYC (DEBOUNCE_CYC)
  ) u_deb (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin_n (pin_n),
    .bus     (in_bus.src)
  );

  logic [NUM_IN-1:0] lvl;
  logic [NUM_IN-1:0] lead;

  assign lvl  = in_bus.level;
  assign lead = in_bus.lead;

  //----------------------------------------------------------------------------
  // Select line decoding
  //----------------------------------------------------------------------------
  // A select line reads high on the pin while it is not asserted.
  logic         sel_a_high;
  logic         sel_b_high;
  gecio_speed_t speed_sel;
  gecio_peak_t  peak_sel;

  assign sel_a_high = ~lvl[IN_SEL_A];
  assign sel_b_high = ~lvl[IN_SEL_B];

  always_comb begin
    speed_sel = gecio_speed_t'({sel_b_high, sel_a_high});
    peak_sel  = GECIO_PK_CURRENT;
    if (lvl[IN_PEAK]) begin
      if (sel_b_high && sel_a_high) begin
        peak_sel = GECIO_PK_CURRENT;
      end else if (sel_b_high) begin
        peak_sel = GECIO_PK_MAX;
      end else if (sel_a_high) begin
        peak_sel = GECIO_PK_MIN;
      end else begin
        peak_sel = GECIO_PK_DIFF;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_peak_mode <= GECIO_PK_CURRENT;
    end else begin
      o_peak_mode <= peak_sel;
    end
  end

  //----------------------------------------------------------------------------
  // Spindle motion
  //----------------------------------------------------------------------------
  gecio_mot_t          mot_q;
  gecio_mot_t          mot_d;
  logic [SETTLE_W-1:0] settle_q;
  logic                want_up;
  logic                want_down;
  logic                settle_done;

  // Opposite requests together cancel each other and stop the spindle.
  assign want_up     = sole_request(lvl[IN_UP], lvl[IN_DOWN]);
  assign want_down   = sole_request(lvl[IN_DOWN], lvl[IN_UP]);
  assign settle_done = (settle_q == SETTLE_W'(SETTLE_CYC - 1));

  always_comb begin
    mot_d = mot_q;
    case (mot_q)
      GECIO_MOT_IDLE: begin
        if (want_up) begin
          mot_d = GECIO_MOT_UP;
        end else if (want_down) begin
          mot_d = GECIO_MOT_DOWN;
        end
      end
      GECIO_MOT_UP: begin
        if (!want_up) begin
          mot_d = GECIO_MOT_SETTLE;
        end
      end
      GECIO_MOT_DOWN: begin
        if (!want_down) begin
          mot_d = GECIO_MOT_SETTLE;
        end
      end
      GECIO_MOT_SETTLE: begin
        if (settle_done) begin
          mot_d = GECIO_MOT_IDLE;
        end
      end
      default: begin
        mot_d = GECIO_MOT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mot_q <= GECIO_MOT_IDLE;
    end else begin
      mot_q <= mot_d;
    end
  end

  // The stop pause is enforced here too, so a hasty controller cannot restart early.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_q <= '0;
    end else if (mot_q == GECIO_MOT_SETTLE && !settle_done) begin
      settle_q <= settle_q + 1'b1;
    end else begin
      settle_q <= '0;
    end
  end

  // Speed follows the select lines only while idle, so a change mid-travel has no effect.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_motor_speed <= GECIO_SPD_1MM;
      o_motor_up    <= 1'b0;
      o_motor_down  <= 1'b0;
    end else begin
      if (mot_q == GECIO_MOT_IDLE) begin
        o_motor_speed <= speed_sel;
      end
      o_motor_up   <= (mot_d == GECIO_MOT_UP);
      o_motor_down <= (mot_d == GECIO_MOT_DOWN);
    end
  end

  //----------------------------------------------------------------------------
  // Pedal
  //----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pedal_press <= 1'b0;
    end else begin
      o_pedal_press <= lead[IN_PEDAL] || lead[IN_FOOT];
    end
  end

  //----------------------------------------------------------------------------
  // Hold and display freeze
  //----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hold_active   <= 1'b0;
      o_display_value <= '0;
    end else begin
      o_hold_active <= lvl[IN_HOLD];
      if (!lvl[IN_HOLD]) begin
        o_display_value <= i_live_value;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Error flag
  //----------------------------------------------------------------------------
  logic err_q;
  logic err_clr_d;

  // A new error in the same cycle as the hold edge wins, so no clear is reported then.
  assign err_clr_d = lead[IN_HOLD] && err_q && !i_error_event;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_q         <= 1'b0;
      o_error_clear <= 1'b0;
    end else begin
      o_error_clear <= err_clr_d;
      if (i_error_event) begin
        err_q <= 1'b1;
      end else if (lead[IN_HOLD]) begin
        err_q <= 1'b0;
      end
    end
  end

  assign o_error_pending = err_q;

  //----------------------------------------------------------------------------
  // Preset and peak clear
  //----------------------------------------------------------------------------
  logic peak_clr_d;
  logic preset_d;

  assign peak_clr_d = lead[IN_PRESET] && peak_hold_active(lvl[IN_HOLD], o_peak_mode);
  assign preset_d   = lead[IN_PRESET] && !peak_hold_active(lvl[IN_HOLD], o_peak_mode);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_preset_load <= 1'b0;
      o_peak_clear  <= 1'b0;
    end else begin
      o_preset_load <= preset_d;
      o_peak_clear  <= peak_clr_d;
    end
  end

  //----------------------------------------------------------------------------
  // Open-collector outputs
  //----------------------------------------------------------------------------
  // Each pin only ever pulls low, so the enable alone decides whether it conducts.
  logic oc_level;

  gecio_oc_out u_out (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_judge_sel   (i_judge_sel),
    .i_error       (err_q),
    .i_count_mode  (i_count_mode),
    .i_top_dead    (i_top_dead),
    .i_work_detect (i_work_detect),
    .o_judge_oe    (o_judge_out_oe),
    .o_count_oe    (o_count_mode_out_oe),
    .o_top_oe      (o_top_dead_point_out_oe),
    .o_work_oe     (o_workpiece_out_oe),
    .o_level       (oc_level)
  );

  assign o_judge_out_o          = {NUM_JUDGE{oc_level}};
  assign o_count_mode_out_o     = oc_level;
  assign o_top_dead_point_out_o = oc_level;
  assign o_workpiece_out_o      = oc_level;

endmodule

// ===== inc/gecio_pkg.sv
//------------------------------------------------------------------------------
// Overview of operation
// - Asserted outputs switch the open-collector transistor on, pulling the line low.
// - Normal judgment drives only the one matching judgment output of five.
// - On error, first and fifth judgment outputs are driven low together.
// - Count-mode output is low while the unit operates in count mode.
// - Top-dead-point output is low while the spindle sits at top dead point.
// - Workpiece output is low while a workpiece is detected.
// - Peak input with select lines chooses current, maximum, minimum or difference.
// - Select lines b,a pick speed: HH 8, HL 4, LH 2, LL 1 mm/s.
// - Port pedal input acts exactly like the separate foot switch.
// - Hold input freezes the displayed value; release resumes updating.
// - Leading edge of hold clears a pending error.
// - Preset loads preset value; in peak mode during hold it clears the peak.
//------------------------------------------------------------------------------
package gecio_pkg;

  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SPEED_SETTLE_MS = 50;
  localparam int unsigned DEBOUNCE_US     = 1000;
  localparam int unsigned SETTLE_CYC_DEF  = SPEED_SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC_DEF = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SETTLE_W       = 21;
  localparam int unsigned DEB_W          = 16;
  localparam int unsigned DISP_W         = 24;
  localparam int unsigned NUM_JUDGE      = 5;

  // Bit positions of the control inputs in the debounced vector.
  localparam int unsigned IN_SEL_A  = 0;
  localparam int unsigned IN_SEL_B  = 1;
  localparam int unsigned IN_PEAK   = 2;
  localparam int unsigned IN_UP     = 3;
  localparam int unsigned IN_DOWN   = 4;
  localparam int unsigned IN_PEDAL  = 5;
  localparam int unsigned IN_HOLD   = 6;
  localparam int unsigned IN_PRESET = 7;
  localparam int unsigned IN_FOOT   = 8;
  localparam int unsigned NUM_IN    = 9;

  localparam int unsigned JUDGE_FIRST = 0;
  localparam int unsigned JUDGE_LAST  = 4;

  typedef enum logic [1:0] {
    GECIO_SPD_1MM = 2'b00,
    GECIO_SPD_2MM = 2'b01,
    GECIO_SPD_4MM = 2'b10,
    GECIO_SPD_8MM = 2'b11
  } gecio_speed_t;

  typedef enum logic [1:0] {
    GECIO_PK_CURRENT = 2'b00,
    GECIO_PK_MAX     = 2'b01,
    GECIO_PK_MIN     = 2'b10,
    GECIO_PK_DIFF    = 2'b11
  } gecio_peak_t;

  typedef enum logic [1:0] {
    GECIO_MOT_IDLE   = 2'b00,
    GECIO_MOT_UP     = 2'b01,
    GECIO_MOT_DOWN   = 2'b10,
    GECIO_MOT_SETTLE = 2'b11
  } gecio_mot_t;

endpackage

// ===== inc/gecio_in_if.sv
`timescale 1ns/1ps
interface gecio_in_if;
  import gecio_pkg::*;
  logic [NUM_IN-1:0] level;
  logic [NUM_IN-1:0] lead;
  modport src (output level, output lead);
  modport dst (input level, input lead);
endinterface

// ===== rtl/gecio_debounce.sv
`timescale 1ns/1ps
module gecio_debounce
  import gecio_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC_DEF
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [NUM_IN-1:0] i_pin_n,
  gecio_in_if.src                bus
);

  //----------------------------------------------------------------------------
  // Per-input synchroniser and debounce filter
  //----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_in
      logic             sync0_q;
      logic             sync1_q;
      logic             stable_q;
      logic             lead_q;
      logic [DEB_W-1:0] cnt_q;
      logic             done;

      assign done = (sync1_q != stable_q) && (cnt_q == DEB_W'(DEB_CYC - 1));

      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync0_q <= 1'b1;
          sync1_q <= 1'b1;
        end else begin
          sync0_q <= i_pin_n[g];
          sync1_q <= sync0_q;
        end
      end

      // A level must hold for the whole window, so contact bounce never passes.
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_q    <= '0;
          stable_q <= 1'b1;
          lead_q   <= 1'b0;
        end else begin
          lead_q <= done && stable_q;
          if (done) begin
            stable_q <= sync1_q;
            cnt_q    <= '0;
          end else if (sync1_q != stable_q) begin
            cnt_q <= cnt_q + 1'b1;
          end else begin
            cnt_q <= '0;
          end
        end
      end

      assign bus.level[g] = ~stable_q;
      assign bus.lead[g]  = lead_q;
    end
  endgenerate

endmodule

// ===== rtl/gecio_oc_out.sv
`timescale 1ns/1ps
module gecio_oc_out
  import gecio_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic [2:0]           i_judge_sel,
  input  wire logic                 i_error,
  input  wire logic                 i_count_mode,
  input  wire logic                 i_top_dead,
  input  wire logic                 i_work_detect,
  output logic      [NUM_JUDGE-1:0] o_judge_oe,
  output logic                      o_count_oe,
  output logic                      o_top_oe,
  output logic                      o_work_oe,
  output logic                      o_level
);

  //----------------------------------------------------------------------------
  // Open-collector drive, an enable high turns the transistor on
  //----------------------------------------------------------------------------
  logic [NUM_JUDGE-1:0] onehot;
  logic [NUM_JUDGE-1:0] err_pat;

  always_comb begin
    onehot  = '0;
    err_pat = '0;
    for (int i = 0; i < NUM_JUDGE; i++) begin
      onehot[i] = (i_judge_sel == 3'(i));
    end
    err_pat[JUDGE_FIRST] = 1'b1;
    err_pat[JUDGE_LAST]  = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_judge_oe <= '0;
      o_count_oe <= 1'b0;
      o_top_oe   <= 1'b0;
      o_work_oe  <= 1'b0;
      o_level    <= 1'b0;
    end else begin
      o_judge_oe <= i_error ? err_pat : onehot;
      o_count_oe <= i_count_mode;
      o_top_oe   <= i_top_dead;
      o_work_oe  <= i_work_detect;
      o_level    <= 1'b0;
    end
  end

endmodule

// ===== tb/gecio_props.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Port checker for the control port block.
// -----------------------------------------------------------------------------
module gecio_props
  import gecio_pkg::*;
(
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire logic [2:0]           i_judge_sel,
  input wire logic                 i_count_mode,
  input wire logic                 i_top_dead,
  input wire logic                 i_work_detect,
  input wire logic [NUM_JUDGE-1:0] o_judge_out_oe,
  input wire logic                 o_count_mode_out_oe,
  input wire logic                 o_top_dead_point_out_oe,
  input wire logic                 o_workpiece_out_oe,
  input wire logic                 o_motor_up,
  input wire logic                 o_motor_down,
  input wire gecio_speed_t         o_motor_speed,
  input wire gecio_peak_t          o_peak_mode,
  input wire logic                 o_hold_active,
  input wire logic [DISP_W-1:0]    o_display_value,
  input wire logic                 o_error_pending,
  input wire logic                 o_error_clear,
  input wire logic                 o_preset_load,
  input wire logic                 o_peak_clear
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Two samples are needed because the forced error pattern is registered.
  sequence s_err_kept;
    o_error_pending ##1 o_error_pending;
  endsequence
  sequence s_held;
    o_hold_active ##1 o_hold_active;
  endsequence
  sequence s_moving;
    (o_motor_up || o_motor_down) [*2];
  endsequence

  chk_judge_onehot: assert property ((!o_error_pending && i_judge_sel < 3'h5) ##1
    !o_error_pending |-> o_judge_out_oe == (5'h01 << $past(i_judge_sel)))
    else $error("judge output not one-hot for result");
  chk_error_pair: assert property (s_err_kept |-> o_judge_out_oe == 5'h11)
    else $error("error pattern missing on judge outputs");
  chk_count_follow: assert property (i_count_mode |=> o_count_mode_out_oe)
    else $error("count mode output not driven");
  chk_top_follow: assert property (i_top_dead |=> o_top_dead_point_out_oe)
    else $error("top dead point output not driven");
  chk_work_follow: assert property (!i_work_detect |=> !o_workpiece_out_oe)
    else $error("workpiece output driven without detection");
  chk_hold_freeze: assert property (s_held |-> $stable(o_display_value))
    else $error("display changed while held");
  chk_error_clear: assert property (o_error_clear == $fell(o_error_pending))
    else $error("error clear pulse and pending flag disagree");
  chk_preset_pulse: assert property (o_preset_load |=> !o_preset_load)
    else $error("preset load longer than one cycle");
  chk_peak_clear: assert property (o_peak_clear |-> o_hold_active && !o_preset_load
    && o_peak_mode != GECIO_PK_CURRENT)
    else $error("peak clear outside held peak mode");
  chk_speed_stable: assert property (s_moving |-> $stable(o_motor_speed))
    else $error("speed changed during motion");
endmodule

bind gecio_top gecio_props chk_u (.i_clk, .i_rst_n, .i_judge_sel, .i_count_mode, .i_top_dead,
  .i_work_detect, .o_judge_out_oe, .o_count_mode_out_oe, .o_top_dead_point_out_oe,
  .o_workpiece_out_oe, .o_motor_up, .o_motor_down, .o_motor_speed, .o_peak_mode,
  .o_hold_active, .o_display_value, .o_error_pending, .o_error_clear, .o_preset_load,
  .o_peak_clear);

// ===== tb/gecio_plc_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// External controller: turns asserted requests into active-low pins.
// -----------------------------------------------------------------------------
module gecio_plc_model
  import gecio_pkg::*;
#(
  parameter int unsigned STOP_WAIT = 8
) (
  input  wire logic [NUM_IN-1:0] i_req,
  input  wire logic              i_clk,
  output logic      [NUM_IN-1:0] o_pin_n
);
  logic [NUM_IN-1:0] drive_q = '0;
  int unsigned       idle_q  = 0;

  // Speed lines only move after the spindle has stood still long enough.
  always @(negedge i_clk) begin
    if (i_req[IN_UP] | i_req[IN_DOWN] | drive_q[IN_UP] | drive_q[IN_DOWN]) begin
      idle_q <= 0;
    end else begin
      idle_q <= idle_q + 1;
    end
    drive_q[NUM_IN-1:2] <= i_req[NUM_IN-1:2];
    if (idle_q >= STOP_WAIT) begin
      drive_q[1:0] <= i_req[1:0];
    end
  end
  assign o_pin_n = ~drive_q;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import gecio_pkg::*;
  localparam int unsigned DEB = 4;
  localparam int unsigned HT  = DEB + 6;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic [NUM_IN-1:0]    req = '0;
  wire  [NUM_IN-1:0]    pin_n;
  logic [2:0]           jsel = 3'h0;
  logic                 err_ev = 1'b0;
  logic                 cnt_md = 1'b0;
  logic                 top_dp = 1'b0;
  logic                 work = 1'b0;
  logic [DISP_W-1:0]    live = 24'h000000;
  logic [NUM_JUDGE-1:0] j_o;
  logic [NUM_JUDGE-1:0] j_oe;
  logic                 cm_oe, tp_oe, wk_oe, m_up, m_dn, hold_act, err_p;
  logic                 err_clr, pre_ld, pk_clr, pedal;
  logic                 cm_o, tp_o, wk_o;
  gecio_speed_t         speed;
  gecio_peak_t          peak;
  logic [DISP_W-1:0]    disp;
  int                   n_errors = 0;
  int                   comparisons = 0;
  int                   n_pre = 0, n_pk = 0, n_clr = 0, n_ped = 0;
  int                   c0, c1;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    n_pre += int'(pre_ld === 1'b1);
    n_pk += int'(pk_clr === 1'b1);
    n_clr += int'(err_clr === 1'b1);
    n_ped += int'(pedal === 1'b1);
  end

  gecio_plc_model #(.STOP_WAIT(8)) plc_u (.i_req(req), .i_clk(clk), .o_pin_n(pin_n));

  gecio_top #(.DEBOUNCE_CYC(DEB), .SETTLE_CYC(8)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_select_line_a_n(pin_n[IN_SEL_A]),
    .i_select_line_b_n(pin_n[IN_SEL_B]), .i_peak_select_n(pin_n[IN_PEAK]),
    .i_spindle_ascend_n(pin_n[IN_UP]), .i_spindle_descend_in_n(pin_n[IN_DOWN]),
    .i_pedal_in_n(pin_n[IN_PEDAL]), .i_hold_n(pin_n[IN_HOLD]), .i_preset_n(pin_n[IN_PRESET]),
    .i_foot_switch_n(pin_n[IN_FOOT]), .i_judge_sel(jsel), .i_error_event(err_ev),
    .i_count_mode(cnt_md), .i_top_dead(top_dp), .i_work_detect(work), .i_live_value(live),
    .o_judge_out_o(j_o), .o_judge_out_oe(j_oe), .o_count_mode_out_o(cm_o),
    .o_count_mode_out_oe(cm_oe), .o_top_dead_point_out_o(tp_o), .o_top_dead_point_out_oe(tp_oe),
    .o_workpiece_out_o(wk_o), .o_workpiece_out_oe(wk_oe), .o_motor_up(m_up), .o_motor_down(m_dn),
    .o_motor_speed(speed), .o_peak_mode(peak), .o_hold_active(hold_act),
    .o_display_value(disp), .o_error_pending(err_p), .o_error_clear(err_clr),
    .o_preset_load(pre_ld), .o_peak_clear(pk_clr), .o_pedal_press(pedal));

  // ---------------------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Waits long enough for the debounced level and its registered effect.
  task automatic drive(input int idx, input logic v);
    req[idx] <= v;
    cyc(HT);
  endtask
  task automatic complete_run;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_outputs;
    for (int s = 0; s < 8; s++) begin
      jsel = 3'(s);
      cyc(2);
      chk(24'(j_oe), (s < 5) ? 24'h1 << s : 24'h0);
      chk(24'(j_o), 24'h0);
    end
    for (int k = 0; k < 2; k++) begin
      {cnt_md, top_dp, work} = {3{k[0]}};
      cyc(2);
      chk(24'(cm_oe), 24'(k[0]));
      chk(24'(tp_oe), 24'(k[0]));
      chk(24'(wk_oe), 24'(k[0]));
      chk(24'({cm_o, tp_o, wk_o}), 24'h0);
    end
  endtask

  task automatic t_error_hold;
    live = 24'h00a5a5;
    req[IN_HOLD] <= 1'b1;
    cyc(2);
    drive(IN_HOLD, 1'b0);
    chk(24'(hold_act), 24'h0);
    chk(disp, 24'h00a5a5);
    err_ev = 1'b1;
    cyc(1);
    err_ev = 1'b0;
    cyc(2);
    chk(24'(j_oe), 24'h11);
    c0 = n_clr;
    drive(IN_HOLD, 1'b1);
    chk(24'(n_clr - c0), 24'h1);
    chk(24'({hold_act, err_p}), 24'h2);
    live = 24'h0012ab;
    cyc(3);
    chk(disp, 24'h00a5a5);
    drive(IN_HOLD, 1'b0);
    chk(disp, 24'h0012ab);
  endtask

  task automatic t_peak;
    req[IN_PEAK] <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      req[IN_SEL_B] <= ~i[1];
      req[IN_SEL_A] <= ~i[0];
      cyc(HT + 10);
      chk(24'(peak), 24'(2'b11 ^ i[1:0]));
    end
    req[IN_SEL_B] <= 1'b0;
    req[IN_SEL_A] <= 1'b1;
    cyc(HT + 10);
    c0 = n_pre;
    c1 = n_pk;
    drive(IN_HOLD, 1'b1);
    drive(IN_PRESET, 1'b1);
    chk(24'(n_pk - c1), 24'h1);
    chk(24'(n_pre - c0), 24'h0);
    drive(IN_PRESET, 1'b0);
    drive(IN_HOLD, 1'b0);
    drive(IN_PEAK, 1'b0);
    chk(24'(peak), 24'(GECIO_PK_CURRENT));
    drive(IN_PRESET, 1'b1);
    chk(24'(n_pre - c0), 24'h1);
    drive(IN_PRESET, 1'b0);
  endtask

  task automatic t_motion;
    for (int i = 0; i < 4; i++) begin
      req[IN_SEL_B] <= ~i[1];
      req[IN_SEL_A] <= ~i[0];
      cyc(HT + 10);
      drive(i[0] ? IN_DOWN : IN_UP, 1'b1);
      chk(24'({m_up, m_dn}), i[0] ? 24'h1 : 24'h2);
      chk(24'(speed), 24'(i[1:0]));
      drive(i[0] ? IN_DOWN : IN_UP, 1'b0);
      cyc(12);
    end
    c0 = n_ped;
    drive(IN_PEDAL, 1'b1);
    drive(IN_PEDAL, 1'b0);
    drive(IN_FOOT, 1'b1);
    drive(IN_FOOT, 1'b0);
    chk(24'(n_ped - c0), 24'h2);
  endtask

  initial begin
    cyc(16);
    rst_n = 1'b1;
    cyc(2);
    t_outputs;
    t_error_hold;
    t_peak;
    t_motion;
    complete_run;
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    complete_run;
  end
endmodule
